// [design/tid_regs.svh]
// Opcode codes, operand addresses, reset values and timing counts for the decoder.
`ifndef TID_REGS_SVH
`define TID_REGS_SVH
`define TID_BYTE_SUB 6'h02
`define TID_BYTE_DEC 6'h03
`define TID_BYTE_IOR 6'h04
`define TID_BYTE_AND 6'h05
`define TID_BYTE_XOR 6'h06
`define TID_BYTE_ADD 6'h07
`define TID_BYTE_MOVF 6'h08
`define TID_BYTE_COM 6'h09
`define TID_BYTE_INC 6'h0A
`define TID_BYTE_DECSZ 6'h0B
`define TID_BYTE_RRC 6'h0C
`define TID_BYTE_RLC 6'h0D
`define TID_BYTE_SWAP 6'h0E
`define TID_BYTE_INCSZ 6'h0F
`define TID_GRP_SPECIAL 6'h00
`define TID_GRP_CLEAR 6'h01
`define TID_SPC_NOP 5'h00
`define TID_SPC_OPTION 5'h02
`define TID_SPC_SLEEP 5'h03
`define TID_SPC_WDT 5'h04
`define TID_SPC_DIR_MIN 5'h05
`define TID_SPC_DIR_MAX 5'h07
`define TID_BIT_CLR 4'h4
`define TID_BIT_SET 4'h5
`define TID_BIT_SKIP_LOW 4'h6
`define TID_BIT_SKIP_HIGH 4'h7
`define TID_LIT_RETURN 4'h8
`define TID_LIT_CALL 4'h9
`define TID_LIT_JUMP 3'h5
`define TID_LIT_LOAD 4'hC
`define TID_LIT_OR 4'hD
`define TID_LIT_AND 4'hE
`define TID_LIT_XOR 4'hF
`define TID_TIMER_ADDR 5'h01
`define TID_PORT_ADDR 5'h06
`define TID_DIR_PORT_SEL 3'h6
`define TID_DIR_RESET 8'hFF
`define TID_OSC_PER_INSTR 4
`endif

// [design/tid_pkg.sv]
// Types shared by the instruction decoder modules.
`default_nettype none
package tid_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CLR, OP_MOVW, OP_MOVF, OP_COM,
    OP_INC, OP_DEC, OP_RLC, OP_RRC, OP_SWAP, OP_BCLR, OP_BSET, OP_BTEST, OP_LIT_AND,
    OP_LIT_OR, OP_LIT_XOR, OP_LIT_LOAD, OP_CALL, OP_RET, OP_JUMP, OP_OPTION, OP_SLEEP,
    OP_WDT, OP_DIR
  } tid_op_e;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } tid_phase_e;
  typedef enum logic [1:0] {
    EX_RUN = 2'h1,
    EX_FLUSH = 2'h2
  } tid_exec_e;
  typedef enum logic [1:0] {
    SK_NONE, SK_ZERO, SK_BIT_LOW, SK_BIT_HIGH
  } tid_skip_e;
endpackage : tid_pkg
`default_nettype wire

// [design/tid_cycle_timer.sv]
// Four-phase instruction cycle sequencer driven by the oscillator clock.
`default_nettype none
module tid_cycle_timer (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output logic o_q1,
  output logic o_q4
);
  tid_pkg::tid_phase_e phase_reg;
  tid_pkg::tid_phase_e phase_next;

  always_comb begin
    case (phase_reg)
      tid_pkg::PH_Q1: phase_next = tid_pkg::PH_Q2;
      tid_pkg::PH_Q2: phase_next = tid_pkg::PH_Q3;
      tid_pkg::PH_Q3: phase_next = tid_pkg::PH_Q4;
      tid_pkg::PH_Q4: phase_next = tid_pkg::PH_Q1;
      default: phase_next = tid_pkg::PH_Q1;
    endcase
  end

  // Reset lands in the last phase, so the first edge closes a cycle and the second takes a word.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_reg <= tid_pkg::PH_Q4;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign o_q1 = (phase_reg == tid_pkg::PH_Q1);
  assign o_q4 = (phase_reg == tid_pkg::PH_Q4);
endmodule : tid_cycle_timer
`default_nettype wire

// [design/tid_pin_sync.sv]
// Two-stage synchroniser for the port pin levels.
`default_nettype none
module tid_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_async,
  output logic [7:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_reg <= 1'h0;
          sync_reg <= 1'h0;
        end else begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate
endmodule : tid_pin_sync
`default_nettype wire

// [design/tid_decoder.sv]
// Twelve-bit instruction decoder with skip sequencing and port side effects.
`include "tid_regs.svh"
`default_nettype none
// Overview of operation
// - Decode add and subtract, update C DC Z.
// - Destination bit picks accumulator or file register.
// - AND, OR, XOR with file update zero only.
// - Decrement/increment skip on zero, no flags.
// - Rotates through carry update only carry.
// - Bit clear/set one cycle, no flags.
// - Bit test skip discards prefetch, runs no-op.
// - Literal ops to accumulator, load leaves zero.
// - Call and literal return take two cycles.
// - PC writes clear bit 8 except jump.
// - Standby and watchdog clear touch timeout flags.
// - Direction load operand 6 copies accumulator.
// - Port read-modify-write uses sensed pin levels.
// - Marked timer writes clear assigned prescaler.
// - Four oscillator periods per instruction cycle.
module tid_decoder (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_instr,
  input wire logic [7:0] i_acc,
  input wire logic i_result_zero,
  input wire logic i_tested_bit,
  input wire logic i_prescaler_on_timer,
  input wire logic [7:0] i_port_pins,
  output tid_pkg::tid_op_e o_op,
  output logic o_dest_file,
  output logic [4:0] o_file_addr,
  output logic [2:0] o_bit_sel,
  output logic [8:0] o_literal,
  output logic o_upd_c,
  output logic o_upd_dc,
  output logic o_upd_z,
  output logic o_pc_write,
  output logic o_pc_bit8_clear,
  output logic o_flag_wake_upd,
  output logic o_src_from_pins,
  output logic [7:0] o_pin_levels,
  output logic o_prescaler_clear,
  output logic [7:0] o_dir_latch,
  output logic o_flush,
  output logic o_cycle_start
);
  logic q1;
  logic q4;
  logic [7:0] pins_sync;
  tid_pkg::tid_exec_e exec_reg;
  tid_pkg::tid_skip_e skip_reg;
  tid_pkg::tid_op_e d_op;
  tid_pkg::tid_skip_e d_skip;
  logic d_c, d_dc, d_z, d_dest, d_pc, d_file, d_note4, d_has_d, d_dir;
  logic [5:0] grp;
  logic skip_taken;

  tid_cycle_timer u_cycle (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .o_q1(q1),
    .o_q4(q4)
  );

  tid_pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_port_pins),
    .o_sync(pins_sync)
  );

  assign grp = i_instr[11:6];

  always_comb begin
    d_op = tid_pkg::OP_NOP;
    d_skip = tid_pkg::SK_NONE;
    d_c = 1'h0;
    d_dc = 1'h0;
    d_z = 1'h0;
    d_dest = i_instr[5];
    d_pc = 1'h0;
    d_file = 1'h1;
    d_note4 = 1'h1;
    d_has_d = 1'h1;
    d_dir = 1'h0;
    if (i_instr[11:10] == 2'h0 && grp != `TID_GRP_SPECIAL && grp != `TID_GRP_CLEAR) begin
      case (grp)
        `TID_BYTE_ADD: begin d_op = tid_pkg::OP_ADD; d_c = 1'h1; d_dc = 1'h1; d_z = 1'h1; end
        `TID_BYTE_SUB: begin d_op = tid_pkg::OP_SUB; d_c = 1'h1; d_dc = 1'h1; d_z = 1'h1; end
        `TID_BYTE_AND: begin d_op = tid_pkg::OP_AND; d_z = 1'h1; end
        `TID_BYTE_IOR: begin d_op = tid_pkg::OP_OR; d_z = 1'h1; end
        `TID_BYTE_XOR: begin d_op = tid_pkg::OP_XOR; d_z = 1'h1; end
        `TID_BYTE_DECSZ: begin d_op = tid_pkg::OP_DEC; d_skip = tid_pkg::SK_ZERO; end
        `TID_BYTE_INCSZ: begin d_op = tid_pkg::OP_INC; d_skip = tid_pkg::SK_ZERO; end
        `TID_BYTE_RLC: begin d_op = tid_pkg::OP_RLC; d_c = 1'h1; end
        `TID_BYTE_RRC: begin d_op = tid_pkg::OP_RRC; d_c = 1'h1; end
        `TID_BYTE_DEC: begin d_op = tid_pkg::OP_DEC; d_z = 1'h1; end
        `TID_BYTE_INC: begin d_op = tid_pkg::OP_INC; d_z = 1'h1; end
        `TID_BYTE_MOVF: begin d_op = tid_pkg::OP_MOVF; d_z = 1'h1; end
        `TID_BYTE_COM: begin d_op = tid_pkg::OP_COM; d_z = 1'h1; d_note4 = 1'h0; end
        `TID_BYTE_SWAP: d_op = tid_pkg::OP_SWAP;
        default: d_op = tid_pkg::OP_NOP;
      endcase
    end else if (grp == `TID_GRP_CLEAR) begin
      d_has_d = 1'h0;
      d_z = 1'h1;
      d_op = tid_pkg::OP_CLR;
      d_dest = i_instr[5];
      d_file = 1'h0;
      d_note4 = i_instr[5];
    end else if (grp == `TID_GRP_SPECIAL) begin
      d_has_d = 1'h0;
      d_file = 1'h0;
      d_note4 = 1'h0;
      if (i_instr[5]) begin
        d_op = tid_pkg::OP_MOVW;
        d_note4 = 1'h1;
        d_dest = 1'h1;
      end else begin
        d_dest = 1'h0;
        case (i_instr[4:0])
          `TID_SPC_NOP: d_op = tid_pkg::OP_NOP;
          `TID_SPC_OPTION: d_op = tid_pkg::OP_OPTION;
          `TID_SPC_SLEEP: d_op = tid_pkg::OP_SLEEP;
          `TID_SPC_WDT: d_op = tid_pkg::OP_WDT;
          default: begin
            if (i_instr[4:0] >= `TID_SPC_DIR_MIN && i_instr[4:0] <= `TID_SPC_DIR_MAX) begin
              d_op = tid_pkg::OP_DIR;
              d_dir = (i_instr[2:0] == `TID_DIR_PORT_SEL);
            end
          end
        endcase
      end
    end else begin
      d_has_d = 1'h0;
      d_dest = 1'h0;
      d_file = 1'h0;
      d_note4 = 1'h0;
      if (i_instr[11:9] == `TID_LIT_JUMP) begin
        d_op = tid_pkg::OP_JUMP;
        d_pc = 1'h1;
      end else begin
        case (i_instr[11:8])
          `TID_BIT_CLR: begin d_op = tid_pkg::OP_BCLR; d_dest = 1'h1; d_file = 1'h1; end
          `TID_BIT_SET: begin d_op = tid_pkg::OP_BSET; d_dest = 1'h1; d_file = 1'h1; end
          `TID_BIT_SKIP_LOW: begin d_op = tid_pkg::OP_BTEST; d_skip = tid_pkg::SK_BIT_LOW; end
          `TID_BIT_SKIP_HIGH: begin d_op = tid_pkg::OP_BTEST; d_skip = tid_pkg::SK_BIT_HIGH; end
          `TID_LIT_AND: begin d_op = tid_pkg::OP_LIT_AND; d_z = 1'h1; end
          `TID_LIT_OR: begin d_op = tid_pkg::OP_LIT_OR; d_z = 1'h1; end
          `TID_LIT_XOR: begin d_op = tid_pkg::OP_LIT_XOR; d_z = 1'h1; end
          `TID_LIT_LOAD: d_op = tid_pkg::OP_LIT_LOAD;
          `TID_LIT_CALL: begin d_op = tid_pkg::OP_CALL; d_pc = 1'h1; end
          `TID_LIT_RETURN: begin d_op = tid_pkg::OP_RET; d_pc = 1'h1; end
          default: d_op = tid_pkg::OP_NOP;
        endcase
        d_note4 = d_file;
        d_has_d = 1'h0;
      end
    end
  end

  // A discarded slot decodes as a no-op whatever word memory presents.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_op <= tid_pkg::OP_NOP;
      skip_reg <= tid_pkg::SK_NONE;
      o_dest_file <= 1'h0;
      o_file_addr <= 5'h00;
      o_bit_sel <= 3'h0;
      o_literal <= 9'h000;
      o_upd_c <= 1'h0;
      o_upd_dc <= 1'h0;
      o_upd_z <= 1'h0;
      o_pc_write <= 1'h0;
      o_pc_bit8_clear <= 1'h0;
      o_flag_wake_upd <= 1'h0;
      o_src_from_pins <= 1'h0;
      o_prescaler_clear <= 1'h0;
      o_flush <= 1'h0;
    end else if (q1) begin
      if (exec_reg == tid_pkg::EX_FLUSH) begin
        o_op <= tid_pkg::OP_NOP;
        skip_reg <= tid_pkg::SK_NONE;
        o_dest_file <= 1'h0;
        o_upd_c <= 1'h0;
        o_upd_dc <= 1'h0;
        o_upd_z <= 1'h0;
        o_pc_write <= 1'h0;
        o_pc_bit8_clear <= 1'h0;
        o_flag_wake_upd <= 1'h0;
        o_src_from_pins <= 1'h0;
        o_prescaler_clear <= 1'h0;
        o_flush <= 1'h1;
      end else begin
        o_op <= d_op;
        skip_reg <= d_skip;
        o_dest_file <= d_dest;
        o_file_addr <= i_instr[4:0];
        o_bit_sel <= i_instr[7:5];
        o_literal <= i_instr[8:0];
        o_upd_c <= d_c;
        o_upd_dc <= d_dc;
        o_upd_z <= d_z;
        o_pc_write <= d_pc;
        o_pc_bit8_clear <= d_pc && i_instr[11:9] != `TID_LIT_JUMP;
        o_flag_wake_upd <= d_op == tid_pkg::OP_SLEEP || d_op == tid_pkg::OP_WDT;
        o_src_from_pins <= d_file && i_instr[4:0] == `TID_PORT_ADDR;
        o_prescaler_clear <= d_note4 && i_instr[4:0] == `TID_TIMER_ADDR
            && (!d_has_d || i_instr[5]) && i_prescaler_on_timer;
        o_flush <= 1'h0;
      end
    end
  end

  assign skip_taken = (skip_reg == tid_pkg::SK_ZERO && i_result_zero)
      || (skip_reg == tid_pkg::SK_BIT_LOW && !i_tested_bit)
      || (skip_reg == tid_pkg::SK_BIT_HIGH && i_tested_bit);

  // Branches and taken skips both cost a second cycle spent on a discarded slot.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      exec_reg <= tid_pkg::EX_RUN;
    end else if (q4) begin
      if (o_pc_write || skip_taken) begin
        exec_reg <= tid_pkg::EX_FLUSH;
      end else begin
        exec_reg <= tid_pkg::EX_RUN;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dir_latch <= `TID_DIR_RESET;
    end else if (q1 && exec_reg == tid_pkg::EX_RUN && d_dir) begin
      o_dir_latch <= i_acc;
    end
  end

  // Pins are sampled continuously; a read-modify-write sees levels three edges old.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_levels <= 8'h00;
      o_cycle_start <= 1'h0;
    end else begin
      o_pin_levels <= pins_sync;
      o_cycle_start <= q1;
    end
  end

  a_add_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (q1 && exec_reg == tid_pkg::EX_RUN && grp == `TID_BYTE_ADD)
    |=> (o_op == tid_pkg::OP_ADD && o_upd_c && o_upd_dc && o_upd_z))
    else $error("Add did not raise all three flag updates.");

  a_dest_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (q1 && exec_reg == tid_pkg::EX_RUN && i_instr[11:10] == 2'h0 && grp[5:1] != 5'h00)
    |=> (o_dest_file == $past(i_instr[5])))
    else $error("Destination bit not followed.");

  a_logic_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_op == tid_pkg::OP_AND || o_op == tid_pkg::OP_OR || o_op == tid_pkg::OP_XOR)
    |-> (o_upd_z && !o_upd_c && !o_upd_dc))
    else $error("Logical file op flags wrong.");

  a_rotate_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_op == tid_pkg::OP_RLC || o_op == tid_pkg::OP_RRC) |-> (o_upd_c && !o_upd_z && !o_upd_dc))
    else $error("Rotate flags wrong.");

  a_skip_flush: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (q4 && skip_taken) |-> ##2 (o_flush && o_op == tid_pkg::OP_NOP) ##1 o_flush[*3] ##1 !o_flush)
    else $error("Taken skip did not yield one discarded cycle.");

  a_pc_bit8: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_pc_write |-> (o_pc_bit8_clear == (o_op != tid_pkg::OP_JUMP)))
    else $error("Program counter bit 8 handling wrong.");

  a_dir_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (q1 && exec_reg == tid_pkg::EX_RUN && i_instr == 12'h006) |=> (o_dir_latch == $past(i_acc)))
    else $error("Direction latch not loaded from accumulator.");

  a_cycle_period: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_cycle_start |=> (!o_cycle_start)[*3] ##1 o_cycle_start)
    else $error("Instruction cycle is not four clocks.");

  a_pins_source: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_src_from_pins && !o_flush) |-> (o_file_addr == `TID_PORT_ADDR))
    else $error("Pin source selected for a non-port register.");

  a_wake_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_flag_wake_upd |-> (o_op == tid_pkg::OP_SLEEP || o_op == tid_pkg::OP_WDT))
    else $error("Timeout flag update on wrong op.");

  a_bit_write_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_op == tid_pkg::OP_BCLR || o_op == tid_pkg::OP_BSET)
    |-> (o_dest_file && !o_upd_z && !o_upd_c && !o_upd_dc && !o_pc_write))
    else $error("Bit clear or set has wrong destination or flags.");

  a_lit_load_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_op == tid_pkg::OP_LIT_LOAD) |-> (!o_upd_z && !o_upd_c && !o_upd_dc && !o_dest_file))
    else $error("Literal load touched a flag or the file.");

  a_call_return: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_op == tid_pkg::OP_CALL || o_op == tid_pkg::OP_RET) |-> (o_pc_write && o_pc_bit8_clear))
    else $error("Call or return did not write the program counter.");

  a_prescaler_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_prescaler_clear |-> (o_file_addr == `TID_TIMER_ADDR && !o_flush))
    else $error("Prescaler clear outside a timer write.");
endmodule : tid_decoder
`default_nettype wire

// [tb/tid_prog_mem.sv]
// Program memory model that hands the decoder one word per instruction cycle.
`default_nettype none
module tid_prog_mem (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output logic [11:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] mem [0:127];
  logic [1:0] ph_reg;
  logic [6:0] ptr_reg;
  // The word moves on at the fetch edge, so it stands for the whole cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_reg <= 2'h0;
      ptr_reg <= 7'h00;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      // The decoder takes its word on the second edge after reset, where this phase reads 1.
      if (ph_reg == 2'h1) ptr_reg <= ptr_reg + 7'h01;
    end
  end
  assign o_word = mem[ptr_reg];
endmodule : tid_prog_mem
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the instruction decoder.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 100;
  localparam int ND = 40;
  localparam logic [13:0] DT [0:ND-1] = '{14'h01C5, 14'h00A6, 14'h22C1, 14'h05FF,
    14'h03E1, 14'h06E6, 14'h17E6, 14'h17E6, 14'h0000, 14'h0900, 14'h0123, 14'h08AB,
    14'h0C00, 14'h0BFF, 14'h0000, 14'h0006, 14'h0005, 14'h0004, 14'h0003, 14'h0002,
    14'h0040, 14'h0061, 14'h0021, 14'h0461, 14'h05A1, 14'h0261, 14'h0E5A, 14'h0D5A,
    14'h0F5A, 14'h0C5A, 14'h0346, 14'h0326, 14'h03A6, 14'h0166, 14'h0106, 14'h0186,
    14'h00C6, 14'h22A6, 14'h0226, 14'h00E1};
  localparam tid_pkg::tid_op_e BOP [0:15] = '{tid_pkg::OP_NOP, tid_pkg::OP_CLR,
    tid_pkg::OP_SUB, tid_pkg::OP_DEC, tid_pkg::OP_OR, tid_pkg::OP_AND, tid_pkg::OP_XOR,
    tid_pkg::OP_ADD, tid_pkg::OP_MOVF, tid_pkg::OP_COM, tid_pkg::OP_INC, tid_pkg::OP_DEC,
    tid_pkg::OP_RRC, tid_pkg::OP_RLC, tid_pkg::OP_SWAP, tid_pkg::OP_INC};
  localparam logic [2:0] BFL [0:15] = '{3'h0, 3'h1, 3'h7, 3'h1, 3'h1, 3'h1, 3'h1, 3'h7,
    3'h1, 3'h1, 3'h1, 3'h0, 3'h4, 3'h4, 3'h0, 3'h0};
  localparam tid_pkg::tid_op_e SPC [0:7] = '{tid_pkg::OP_NOP, tid_pkg::OP_NOP,
    tid_pkg::OP_OPTION, tid_pkg::OP_SLEEP, tid_pkg::OP_WDT, tid_pkg::OP_DIR,
    tid_pkg::OP_DIR, tid_pkg::OP_DIR};
  localparam tid_pkg::tid_op_e LOP [0:7] = '{tid_pkg::OP_RET, tid_pkg::OP_CALL,
    tid_pkg::OP_JUMP, tid_pkg::OP_JUMP, tid_pkg::OP_LIT_LOAD, tid_pkg::OP_LIT_OR,
    tid_pkg::OP_LIT_AND, tid_pkg::OP_LIT_XOR};
  logic i_ref_clk, i_rst_b, i_result_zero, i_tested_bit, i_prescaler_on_timer;
  logic [11:0] i_instr;
  logic [7:0] i_acc, i_port_pins, o_pin_levels, o_dir_latch, dir_q, pins, a;
  tid_pkg::tid_op_e o_op;
  logic o_dest_file, o_upd_c, o_upd_dc, o_upd_z, o_pc_write, o_pc_bit8_clear, o_flush;
  logic o_flag_wake_upd, o_src_from_pins, o_prescaler_clear, o_cycle_start, p, fl;
  logic [4:0] o_file_addr;
  logic [2:0] o_bit_sel;
  logic [8:0] o_literal;
  logic [11:0] wd [0:N-1];
  logic [79:0] q [$];
  logic [79:0] n;
  logic [31:0] rs, r;
  logic [1:0] zb;
  int fail_count, checks, gap;
  tid_prog_mem pm (.i_ref_clk, .i_rst_b, .o_word(i_instr));
  tid_decoder DUT (.i_ref_clk, .i_rst_b, .i_instr, .i_acc, .i_result_zero, .i_tested_bit,
    .i_prescaler_on_timer, .i_port_pins, .o_op, .o_dest_file, .o_file_addr, .o_bit_sel,
    .o_literal, .o_upd_c, .o_upd_dc, .o_upd_z, .o_pc_write, .o_pc_bit8_clear,
    .o_flag_wake_upd, .o_src_from_pins, .o_pin_levels, .o_prescaler_clear, .o_dir_latch,
    .o_flush, .o_cycle_start);
  function automatic logic [31:0] nxt();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : nxt
  // Writes to the program counter file are kept out, since the decoder only flags jump, call and return.
  function automatic logic [11:0] san(input logic [31:0] v);
    logic [11:0] w;
    w = v[11:0];
    if (!w[11] && w[4:0] == 5'h02) w[4:0] = 5'h03;
    if (w[11:6] == 6'h01 && !w[5]) w = 12'h040;
    return w;
  endfunction : san
  task automatic cmp_dec(input logic [39:0] e, input logic [39:0] m, input logic [39:0] g);
    checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("mismatch at %0t exp %h got %h", $time, e & m, g & m);
    end
  endtask : cmp_dec
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp8
  task automatic note(input logic [11:0] w, input logic [7:0] av, input logic pv);
    tid_pkg::tid_op_e op;
    logic [2:0] cdz;
    logic pcw, b8, wk, rd, el, ds;
    op = tid_pkg::OP_NOP;
    cdz = 3'h0;
    {pcw, b8, wk, rd, el, ds} = 6'h00;
    if (w[11:10] == 2'b00) begin
      op = BOP[w[9:6]];
      cdz = BFL[w[9:6]];
      rd = w[9:6] > 4'h1;
      el = w[5] && w[9:6] != 4'h9;
      ds = w[5];
      if (w[9:6] == 4'h0 && w[5]) op = tid_pkg::OP_MOVW;
      else if (w[9:6] == 4'h0) begin
        op = (w[4:3] == 2'b00) ? SPC[w[2:0]] : tid_pkg::OP_NOP;
        wk = op == tid_pkg::OP_SLEEP || op == tid_pkg::OP_WDT;
        if (w[4:0] == 5'h06) dir_q = av;
      end
    end else if (w[11:10] == 2'b01) begin
      op = w[9] ? tid_pkg::OP_BTEST : (w[8] ? tid_pkg::OP_BSET : tid_pkg::OP_BCLR);
      rd = !w[9];
      el = !w[9];
      ds = !w[9];
    end else begin
      op = LOP[w[10:8]];
      pcw = !w[10];
      b8 = !w[10] && !w[9];
      cdz = {2'b00, w[10] && w[9:8] != 2'b00};
    end
    q.push_back({op, ds, w[4:0], w[7:5], w[8:0], cdz, pcw, b8, wk, rd && w[4:0] == 5'h06,
      el && pv && w[4:0] == 5'h01, dir_q, 1'b0, 40'hFF_FFFF_FFFF});
  endtask : note
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5ns i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #(100ns * (N + 20));
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end
  always @(negedge i_ref_clk) begin
    gap = gap + 1;
    if (o_cycle_start === 1'b1) begin
      if (gap < 100) cmp8(8'h04, gap[7:0]);
      gap = 0;
      cmp8(8'h01, {7'h00, q.size() > 0});
      if (q.size() > 0) begin
        n = q.pop_front();
        cmp_dec(n[79:40], n[39:0], {o_op, o_dest_file, o_file_addr, o_bit_sel, o_literal,
          o_upd_c, o_upd_dc, o_upd_z, o_pc_write, o_pc_bit8_clear, o_flag_wake_upd,
          o_src_from_pins, o_prescaler_clear, o_dir_latch, o_flush});
      end
    end
  end
  initial begin
    {i_rst_b, i_result_zero, i_tested_bit, i_prescaler_on_timer} = 4'h1;
    {i_acc, i_port_pins, pins} = {8'h3C, 8'h00, 8'h00};
    {rs, dir_q, fl, fail_count, checks, gap} = {32'h8, 8'hFF, 1'b0, 32'h0, 32'h0, 32'h3E8};
    for (int k = 0; k < N; k++) wd[k] = (k < ND) ? DT[k][11:0] : san(nxt());
    for (int k = 0; k < N; k++) pm.mem[k] = wd[k];
    repeat (2) @(posedge i_ref_clk);
    cmp_dec({tid_pkg::OP_NOP, 26'h0, 8'hFF, 1'b0}, 40'hF8_0001_FFFF, {o_op, o_dest_file,
      o_file_addr, o_bit_sel, o_literal, o_upd_c, o_upd_dc, o_upd_z, o_pc_write,
      o_pc_bit8_clear, o_flag_wake_upd, o_src_from_pins, o_prescaler_clear, o_dir_latch,
      o_flush});
    cmp8(8'h00, {7'h00, o_cycle_start});
    note(wd[0], 8'h3C, 1'b1);
    i_rst_b <= 1'b1;
    for (int k = 0; k < N - 1; k++) begin
      repeat (2) @(posedge i_ref_clk);
      r = nxt();
      zb = (k < ND) ? DT[k][13:12] : r[1:0];
      i_result_zero <= zb[1];
      i_tested_bit <= zb[0];
      @(posedge i_ref_clk);
      if (k > 0) cmp8(pins, o_pin_levels);
      fl = !fl && (wd[k][11:10] == 2'b10 || zb[1] && (wd[k][11:6] == 6'h0B ||
        wd[k][11:6] == 6'h0F) || wd[k][11:9] == 3'b011 && wd[k][8] == zb[0]);
      r = nxt();
      {a, p, pins} = {r[7:0], r[8], r[23:16]};
      i_acc <= a;
      i_prescaler_on_timer <= p;
      i_port_pins <= pins;
      if (fl) q.push_back({tid_pkg::OP_NOP, 26'h0, dir_q, 1'b1, 40'hF8_0001_FFFF});
      else note(wd[k + 1], a, p);
      @(posedge i_ref_clk);
      if (k == ND - 1) $display("directed test done");
    end
    $display("random test done");
    repeat (3) @(posedge i_ref_clk);
    cmp8(8'h00, 8'(q.size()));
    wrap_up();
  end
endmodule : tb
`default_nettype wire
